// ### hdl/lks_defines.svh
`ifndef LKS_DEFINES_SVH
`define LKS_DEFINES_SVH

// start byte layout
`define LKS_SB_FIXED      8'hc0
`define LKS_SB_RS_BIT     5
`define LKS_SB_RW_BIT     4

// register numbers
`define LKS_REG_KEY       4'h0
`define LKS_REG_DATA      4'h1
`define LKS_REG_COL       4'h2
`define LKS_REG_ROW       4'h3
`define LKS_REG_PTA       4'h4
`define LKS_REG_PTB       4'h5
`define LKS_REG_FCR       4'h8

// function_control_one fields
`define LKS_FC_INC_BIT    7
`define LKS_FC_WLS_BIT    6
`define LKS_FC_KT_BIT     5
`define LKS_FC_SHL_BIT    4

// address limits
`define LKS_COL_MAX8      4'h9
`define LKS_COL_MAX6      4'hd
`define LKS_KEY_CNT_LAST  3'h4
`define LKS_ROWS_MAX      18

// key scan timing at the 20 MHz block clock
`define LKS_CLK_HZ        20000000
`define LKS_SCAN_SHORT_MS 5
`define LKS_SCAN_LONG_MS  10
`define LKS_SCAN_SHORT_CYC ((`LKS_CLK_HZ / 1000) * `LKS_SCAN_SHORT_MS)
`define LKS_SCAN_LONG_CYC  ((`LKS_CLK_HZ / 1000) * `LKS_SCAN_LONG_MS)
`define LKS_KEY_READY_SCANS 2

`endif

// ### hdl/lks_pkg.sv
package lks_pkg;

    typedef struct packed {
        logic       rs;
        logic       rd;
        logic [3:0] num;
    } lks_start_t;

    typedef enum logic [1:0] {
        LKS_IDLE,
        LKS_CMD,
        LKS_DATA
    } lks_link_st_t;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] enable;
    } lks_port_t;

endpackage

// ### hdl/lks_serial_link.sv
`timescale 1ns/10ps
`include "lks_defines.svh"

// shift engine: start byte then data bytes, msb first
module lks_serial_link
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // synchronised link pins
    input  wire logic               cs_n_s,
    input  wire logic               sclk_s,
    input  wire logic               sdi_s,
    // decoded events
    output lks_pkg::lks_start_t     start_r,
    output logic                    wr_stb,
    output logic [7:0]              wr_data,
    output logic                    rd_stb,
    input  wire logic [7:0]         rd_data,
    output logic                    sdo_r
);
    lks_pkg::lks_link_st_t st_r;
    logic       sclk_d_r;
    logic [2:0] bit_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic       rise;
    logic       fall;
    logic [7:0] byte_in;

    assign rise    = sclk_s & ~sclk_d_r;
    assign fall    = ~sclk_s & sclk_d_r;
    assign byte_in = {sh_r[6:0], sdi_s};
    assign wr_data = byte_in;
    assign wr_stb  = rise && !cs_n_s && st_r == lks_pkg::LKS_DATA
                     && bit_r == 3'h7 && !start_r.rd;
    // next read word is fetched at byte start so it is ready to shift
    assign rd_stb  = fall && !cs_n_s && st_r == lks_pkg::LKS_DATA
                     && bit_r == 3'h0 && start_r.rd;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            sclk_d_r <= 1'b1;
        else
            sclk_d_r <= sclk_s;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r    <= lks_pkg::LKS_IDLE;
            bit_r   <= 3'h0;
            sh_r    <= 8'h00;
            start_r <= '0;
        end
        else if (cs_n_s)
        begin
            st_r    <= lks_pkg::LKS_CMD;
            bit_r   <= 3'h0;
            // drop the read flag, else the next start byte meets our driver
            start_r <= '0;
        end
        else if (rise)
        begin
            sh_r  <= byte_in;
            bit_r <= bit_r + 3'h1;
            case (st_r)
                lks_pkg::LKS_CMD:
                begin
                    if (bit_r == 3'h7)
                    begin
                        // a bad start byte locks out the frame
                        if ((byte_in & `LKS_SB_FIXED) == `LKS_SB_FIXED)
                        begin
                            start_r.rs  <= byte_in[`LKS_SB_RS_BIT];
                            start_r.rd  <= byte_in[`LKS_SB_RW_BIT];
                            start_r.num <= byte_in[3:0];
                            st_r        <= lks_pkg::LKS_DATA;
                        end
                        else
                            st_r <= lks_pkg::LKS_IDLE;
                    end
                end
                lks_pkg::LKS_DATA: st_r <= lks_pkg::LKS_DATA;
                default:           st_r <= lks_pkg::LKS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_r  <= 8'h00;
            sdo_r <= 1'b0;
        end
        else if (rd_stb)
        begin
            tx_r  <= {rd_data[6:0], 1'b0};
            sdo_r <= rd_data[7];
        end
        else if (fall && !cs_n_s && st_r == lks_pkg::LKS_DATA)
        begin
            tx_r  <= {tx_r[6:0], 1'b0};
            sdo_r <= tx_r[7];
        end
    end
endmodule

// ### hdl/lks_regs.sv
`timescale 1ns/10ps
`include "lks_defines.svh"

module lks_regs
#(
    parameter int SCAN_SHORT = `LKS_SCAN_SHORT_CYC,
    parameter int SCAN_LONG  = `LKS_SCAN_LONG_CYC,
    parameter bit LARGE      = 1'b0
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // serial link pins
    input  wire logic         cs_n,
    input  wire logic         sclk,
    input  wire logic         sdio_i,
    output logic              sdio_o,
    output logic              sdio_oe,
    output logic              key_ready_flag,
    // key matrix
    output logic [4:0]        row_drive_outputs_n,
    input  wire logic [4:0]   key_col_n,
    // general-purpose ports
    output logic              port_a_pin,
    output logic              port_a_oe,
    output logic [7:0]        port_b_pins,
    output logic [7:0]        port_b_oe,
    // display control to the panel logic
    output logic              common_order_select,
    output logic [4:0]        duty_lines,
    output logic [7:0]        frame_ram_rd_data
);
    logic [1:0]  cs_sy_r;
    logic [1:0]  sck_sy_r;
    logic [1:0]  sdi_sy_r;
    logic [4:0]  col_m_r;
    logic [4:0]  col_s_r;
    lks_pkg::lks_start_t start_r;
    logic        wr_stb;
    logic [7:0]  wr_data;
    logic        rd_stb;
    logic [7:0]  rd_data;
    logic        sdo_r;
    logic [7:0]  fcr_r;
    logic [3:0]  col_r;
    logic [4:0]  row_r;
    lks_pkg::lks_port_t pta_r;
    lks_pkg::lks_port_t ptb_r;
    logic [2:0]  kcnt_r;
    logic [24:0] keys_r;
    logic [24:0] scan_r;
    logic [2:0]  srow_r;
    logic [19:0] tick_r;
    logic [1:0]  seen_r;
    logic        kready_r;
    logic [7:0]  ram_r [0:`LKS_ROWS_MAX*16-1];
    logic [8:0]  ram_a;
    logic [3:0]  col_max;
    logic [4:0]  row_max;
    logic        is_data;
    logic        data_rd;
    logic        scan_end;
    logic [7:0]  wmask;

    // only the second stage of each synchroniser is read
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cs_sy_r  <= 2'h3;
            // link clock idles high: start there so no false edge
            sck_sy_r <= 2'h3;
            sdi_sy_r <= 2'h0;
            col_m_r  <= 5'h1f;
            col_s_r  <= 5'h1f;
        end
        else
        begin
            cs_sy_r  <= {cs_sy_r[0], cs_n};
            sck_sy_r <= {sck_sy_r[0], sclk};
            sdi_sy_r <= {sdi_sy_r[0], sdio_i};
            col_m_r  <= key_col_n;
            col_s_r  <= col_m_r;
        end
    end

    lks_serial_link u_link
    (
        .clk     (clk),
        .rstn    (rstn),
        .cs_n_s  (cs_sy_r[1]),
        .sclk_s  (sck_sy_r[1]),
        .sdi_s   (sdi_sy_r[1]),
        .start_r (start_r),
        .wr_stb  (wr_stb),
        .wr_data (wr_data),
        .rd_stb  (rd_stb),
        .rd_data (rd_data),
        .sdo_r   (sdo_r)
    );

    // RAM select wins over the register number
    assign is_data = start_r.rs || start_r.num == `LKS_REG_DATA;
    assign data_rd = rd_stb && is_data;
    assign sdio_o  = sdo_r;
    assign sdio_oe = start_r.rd && !cs_sy_r[1];

    // duty and word limits
    always_comb
    begin
        case (fcr_r[1:0])
            2'h0:    row_max = LARGE ? 5'd15 : 5'd7;
            2'h1:    row_max = LARGE ? 5'd16 : 5'd8;
            default: row_max = LARGE ? 5'd17 : 5'd9;
        endcase
    end
    assign col_max    = fcr_r[`LKS_FC_WLS_BIT] ? `LKS_COL_MAX6 : `LKS_COL_MAX8;
    assign duty_lines = row_max + 5'd1;
    assign common_order_select = fcr_r[`LKS_FC_SHL_BIT];
    assign wmask = fcr_r[`LKS_FC_WLS_BIT] ? 8'h3f : 8'hff;

    // no reset term: contents survive reset
    always_ff @(posedge clk)
    begin
        if (wr_stb && !start_r.rs && start_r.num == `LKS_REG_FCR)
            fcr_r <= wr_data & 8'hf3;
    end

    // X and Y counters
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            col_r <= 4'h0;
            row_r <= 5'h00;
        end
        else if (wr_stb && !is_data && start_r.num == `LKS_REG_COL)
            col_r <= wr_data[3:0];
        else if (wr_stb && !is_data && start_r.num == `LKS_REG_ROW)
            row_r <= wr_data[4:0];
        else if ((wr_stb && is_data) || data_rd)
        begin
            if (fcr_r[`LKS_FC_INC_BIT])
            begin
                if (col_r == col_max)
                begin
                    col_r <= 4'h0;
                    row_r <= (row_r == row_max) ? 5'h00 : row_r + 5'h01;
                end
                else
                    col_r <= col_r + 4'h1;
            end
            else if (row_r == row_max)
            begin
                row_r <= 5'h00;
                col_r <= (col_r == col_max) ? 4'h0 : col_r + 4'h1;
            end
            else
                row_r <= row_r + 5'h01;
        end
    end

    // storage without reset
    assign ram_a = {row_r, col_r};
    always_ff @(posedge clk)
    begin
        if (wr_stb && is_data)
            ram_r[ram_a] <= wr_data & wmask;
        frame_ram_rd_data <= ram_r[ram_a] & wmask;
    end

    // ports float until written after reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pta_r <= '0;
            ptb_r <= '0;
        end
        else if (wr_stb && !is_data && start_r.num == `LKS_REG_PTA)
        begin
            pta_r.data   <= {7'h00, wr_data[0]};
            pta_r.enable <= 8'hff;
        end
        else if (wr_stb && !is_data && start_r.num == `LKS_REG_PTB)
        begin
            ptb_r.data   <= wr_data;
            ptb_r.enable <= 8'hff;
        end
    end
    assign port_a_pin  = pta_r.data[0];
    assign port_a_oe   = pta_r.enable[0];
    assign port_b_pins = ptb_r.data;
    assign port_b_oe   = ptb_r.enable;

    // read mux
    always_comb
    begin
        rd_data = 8'h00;
        if (is_data)
            rd_data = ram_r[ram_a] & wmask;
        else
            case (start_r.num)
                `LKS_REG_KEY:  rd_data = {kcnt_r,
                                          keys_r[5*kcnt_r +: 5]};
                `LKS_REG_COL:  rd_data = {4'h0, col_r};
                `LKS_REG_ROW:  rd_data = {3'h0, row_r};
                `LKS_REG_PTA:  rd_data = pta_r.data;
                `LKS_REG_PTB:  rd_data = ptb_r.data;
                `LKS_REG_FCR:  rd_data = fcr_r;
                default:       rd_data = 8'h00;
            endcase
    end

    // scan timer, row drive and key capture
    // >= so a period shortened mid-scan wraps at once instead of
    // running the counter round its whole range
    assign scan_end = tick_r >= 20'(fcr_r[`LKS_FC_KT_BIT]
                      ? SCAN_LONG - 1 : SCAN_SHORT - 1);
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tick_r <= 20'h00000;
            srow_r <= 3'h0;
            scan_r <= 25'h0;
        end
        else
        begin
            // if rather than ?: so an unwritten control register
            // cannot leave the count unknown for good
            if (scan_end)
                tick_r <= 20'h00000;
            else
                tick_r <= tick_r + 20'h00001;
            // one row per fifth of a period; sample just before moving
            if (tick_r == 20'(((srow_r + 1) * (fcr_r[`LKS_FC_KT_BIT]
                      ? SCAN_LONG : SCAN_SHORT)) / 5 - 1))
            begin
                scan_r[5*srow_r +: 5] <= ~col_s_r;
                srow_r <= (srow_r == 3'h4) ? 3'h0 : srow_r + 3'h1;
            end
        end
    end
    assign row_drive_outputs_n = ~(5'h01 << srow_r);

    // key data, read counter, ready flag
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            keys_r   <= 25'h0;
            kcnt_r   <= 3'h0;
            seen_r   <= 2'h0;
            kready_r <= 1'b0;
        end
        else
        begin
            if (scan_end)
            begin
                keys_r <= scan_r;
                if (scan_r == 25'h0)
                begin
                    seen_r   <= 2'h0;
                    kready_r <= 1'b0;
                end
                else if (seen_r == 2'(`LKS_KEY_READY_SCANS - 1))
                    kready_r <= 1'b1;
                else
                    seen_r <= seen_r + 2'h1;
            end
            if (rd_stb && !is_data && start_r.num == `LKS_REG_KEY)
                kcnt_r <= (kcnt_r == `LKS_KEY_CNT_LAST)
                          ? 3'h0 : kcnt_r + 3'h1;
        end
    end
    assign key_ready_flag = kready_r;
endmodule

// ### dv/lks_regs_props.sv
`timescale 1ns/10ps
module lks_regs_props
#(
    parameter bit LARGE = 1'b0
)
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // link
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       sdio_o,
    input wire logic       sdio_oe,
    input wire logic       key_ready_flag,
    input wire logic [4:0] key_col_n,
    // ports and display
    input wire logic       port_a_pin,
    input wire logic       port_a_oe,
    input wire logic [7:0] port_b_pins,
    input wire logic [7:0] port_b_oe,
    input wire logic [4:0] duty_lines
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_reset_state: assert property (
        $rose(rstn) |-> !port_a_oe && port_b_oe == 8'h00 && !key_ready_flag)
        else $error("outputs not in reset state after release");
    a_port_a_holds: assert property (
        port_a_oe |=> port_a_oe)
        else $error("port a drive dropped without reset");
    a_port_b_whole: assert property (
        port_b_oe[0] |=> port_b_oe == 8'hff)
        else $error("port b drive not whole or dropped");
    a_idle_stable: assert property (
        cs_n [*8] |-> $stable(port_b_pins) && $stable(port_a_pin))
        else $error("port value changed outside a frame");
    a_sdio_frame: assert property (
        cs_n [*5] |-> !sdio_oe)
        else $error("data line driven outside a frame");
    a_sdo_on_low: assert property (
        sdio_oe && $past(sdio_oe) && $changed(sdio_o) |-> !sclk)
        else $error("read bit changed while link clock high");
    a_duty_legal: assert property (
        $changed(duty_lines) |-> (LARGE ?
            duty_lines inside {5'd16, 5'd17, 5'd18} :
            duty_lines inside {5'd8, 5'd9, 5'd10}))
        else $error("duty line count outside the legal set");
    a_ready_holds: assert property (
        key_ready_flag && key_col_n != 5'h1f |=> key_ready_flag)
        else $error("key ready fell while a key is closed");
endmodule

bind lks_regs lks_regs_props #(.LARGE(LARGE)) u_lks_props
(
    .clk            (clk),
    .rstn           (rstn),
    .cs_n           (cs_n),
    .sclk           (sclk),
    .sdio_o         (sdio_o),
    .sdio_oe        (sdio_oe),
    .key_ready_flag (key_ready_flag),
    .key_col_n      (key_col_n),
    .port_a_pin     (port_a_pin),
    .port_a_oe      (port_a_oe),
    .port_b_pins    (port_b_pins),
    .port_b_oe      (port_b_oe),
    .duty_lines     (duty_lines)
);

// ### dv/lks_host_model.sv
`timescale 1ns/10ps
module lks_host_model
(
    // clock
    input  wire logic       clk,
    // serial link
    output logic            cs_n,
    output logic            sclk,
    output logic            sdio_i,
    input  wire logic       sdio_o,
    input  wire logic       sdio_oe,
    // key matrix
    input  wire logic [4:0] row_n,
    output logic [4:0]      col_n
);
    logic [24:0] keys;
    logic        drv;
    logic        bit_o;

    initial
    begin
        keys = 25'h0;
        cs_n = 1'b1;
        sclk = 1'b1;
        drv = 1'b1;
        bit_o = 1'b1;
    end

    // released line shows the inverse of the last bit, not a held value
    assign sdio_i = sdio_oe ? sdio_o : (drv ? bit_o : ~bit_o);

    // pulled-up columns; a closed switch pulls its column to a low row
    always_comb
    begin
        col_n = 5'h1f;
        for (int i = 0; i < 25; i++)
            if (keys[i] && !row_n[i / 5])
                col_n[i % 5] = 1'b0;
    end

    task automatic hp;
        repeat (4) @(negedge clk);
    endtask

    // one start byte and one data byte, msb first
    task automatic xfer(input logic [7:0] sb, input logic [7:0] wd,
                        output logic [7:0] q);
        logic [15:0] sh;
        sh = {sb, wd};
        cs_n = 1'b0;
        hp();
        for (int i = 15; i >= 0; i--)
        begin
            sclk = 1'b0;
            if (i == 7 && sb[4])
                drv = 1'b0;
            bit_o = sh[i];
            hp();
            q = {q[6:0], sdio_i};
            sclk = 1'b1;
            hp();
        end
        cs_n = 1'b1;
        drv = 1'b1;
        hp();
        hp();
    endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/10ps
module testbench;
    typedef struct packed {
        logic [3:0] n;
        logic [7:0] w;
        logic [7:0] e;
    } lks_row_t;

    logic       clk, rstn, cs_n, sclk, sdio_i, sdio_o, sdio_oe;
    logic       key_ready_flag, port_a_pin, port_a_oe, common_order_select;
    logic [4:0] row_n, key_col_n, duty_lines;
    logic [7:0] port_b_pins, port_b_oe, frame_ram_rd_data;
    int         err_count = 0;
    int         checks_done = 0;
    int         cycles = 0;

    // unmapped number 6 must read zero
    lks_row_t rows [6] = '{'{4'h2, 8'hf5, 8'h05}, '{4'h3, 8'hff, 8'h1f},
        '{4'h4, 8'hff, 8'h01}, '{4'h5, 8'ha5, 8'ha5},
        '{4'h6, 8'h5a, 8'h00}, '{4'h8, 8'hff, 8'hf3}};

    lks_regs #(.SCAN_SHORT(50), .SCAN_LONG(100), .LARGE(1'b0)) DUT
    (
        .clk                 (clk),
        .rstn                (rstn),
        .cs_n                (cs_n),
        .sclk                (sclk),
        .sdio_i              (sdio_i),
        .sdio_o              (sdio_o),
        .sdio_oe             (sdio_oe),
        .key_ready_flag      (key_ready_flag),
        .row_drive_outputs_n (row_n),
        .key_col_n           (key_col_n),
        .port_a_pin          (port_a_pin),
        .port_a_oe           (port_a_oe),
        .port_b_pins         (port_b_pins),
        .port_b_oe           (port_b_oe),
        .common_order_select (common_order_select),
        .duty_lines          (duty_lines),
        .frame_ram_rd_data   (frame_ram_rd_data)
    );

    lks_host_model host
    (
        .clk     (clk),
        .cs_n    (cs_n),
        .sclk    (sclk),
        .sdio_i  (sdio_i),
        .sdio_o  (sdio_o),
        .sdio_oe (sdio_oe),
        .row_n   (row_n),
        .col_n   (key_col_n)
    );

    initial
        clk = 1'b0;
    always #25 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] n, input logic [7:0] d);
        logic [7:0] q;
        host.xfer({4'hc, n}, d, q);
    endtask

    task automatic rd(input logic [3:0] n, output logic [7:0] q);
        host.xfer({4'hd, n}, 8'h00, q);
    endtask

    task automatic do_reset;
        rstn = 1'b0;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
    endtask

    task automatic wait_flag(input logic lvl, output int n);
        n = 0;
        while (key_ready_flag !== lvl && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_count++;
            final_report();
        end
    end

    initial
    begin
        logic [7:0]  q;
        int          n;
        int          k;
        logic [24:0] kset;
        rstn = 1'b0;
        do_reset();
        check({6'h0, port_a_oe, port_b_oe[0]}, 8'h00);
        rd(4'h0, q);
        check(q, 8'h00);
        rd(4'h3, q);
        check(q, 8'h00);
        $display("test reset state done");
        foreach (rows[i])
        begin
            wr(rows[i].n, rows[i].w);
            rd(rows[i].n, q);
            check(q, rows[i].e);
        end
        check({6'h0, port_a_oe, port_a_pin}, 8'h03);
        check(port_b_oe, 8'hff);
        check(port_b_pins, 8'ha5);
        check({7'h0, common_order_select}, 8'h01);
        for (int c = 0; c < 4; c++)
        begin
            wr(4'h8, {6'h0, c[1:0]});
            check({3'h0, duty_lines}, c < 2 ? 8'(8 + c) : 8'h0a);
        end
        check({7'h0, common_order_select}, 8'h00);
        $display("test register table done");
        // addresses loaded once, then a run of words
        wr(4'h8, 8'h82);
        wr(4'h2, 8'h08);
        wr(4'h3, 8'h02);
        wr(4'h1, 8'h11);
        wr(4'h1, 8'h22);
        wr(4'h1, 8'h33);
        rd(4'h2, q);
        check(q, 8'h01);
        rd(4'h3, q);
        check(q, 8'h03);
        wr(4'h2, 8'h09);
        wr(4'h3, 8'h02);
        check(frame_ram_rd_data, 8'h22);
        rd(4'h1, q);
        check(q, 8'h22);
        wr(4'h8, 8'hc2);
        wr(4'h2, 8'h0c);
        wr(4'h3, 8'h05);
        wr(4'h1, 8'hff);
        wr(4'h1, 8'h30);
        rd(4'h3, q);
        check(q, 8'h06);
        wr(4'h2, 8'h0c);
        wr(4'h3, 8'h05);
        rd(4'h1, q);
        check(q, 8'h3f);
        wr(4'h8, 8'h02);
        wr(4'h2, 8'h03);
        wr(4'h3, 8'h09);
        wr(4'h1, 8'h44);
        rd(4'h3, q);
        check(q, 8'h00);
        rd(4'h2, q);
        check(q, 8'h04);
        $display("test address counters done");
        do_reset();
        check({port_b_oe[7:1], port_a_oe}, 8'h00);
        rd(4'h8, q);
        check(q, 8'h02);
        rd(4'h4, q);
        check(q, 8'h00);
        wr(4'h2, 8'h09);
        wr(4'h3, 8'h02);
        rd(4'h1, q);
        check(q, 8'h22);
        $display("test mid-run reset done");
        wr(4'h8, 8'h22);
        kset = 25'h0;
        kset[13] = 1'b1;
        kset[20] = 1'b1;
        host.keys = kset;
        wait_flag(1'b1, n);
        check({7'h0, n > 100 && n <= 320}, 8'h01);
        for (int g = 0; g < 6; g++)
        begin
            k = g % 5;
            rd(4'h0, q);
            check(q, {k[2:0], kset[k * 5 +: 5]});
        end
        host.keys = 25'h0;
        wait_flag(1'b0, n);
        check({7'h0, key_ready_flag}, 8'h00);
        $display("test key scan done");
        final_report();
    end
endmodule
